// [hdl/csr_regs.sv]
// Extended control and converter status registers with latch-until-read bits
//
// Behaviour
// - Control bit 4 selects slow copper edges
// - Control bit 3 disables PLL frequency sensing
// - Control bit 2 disables far-end fault
// - Control bit 1 overrides backup link pin
// - All control bits read/write, reset zero
// - Status 15 fiber PLL on local oscillator
// - Status 14 fiber PLL frequency error
// - Frequency errors suppressed by disable or filter reset
// - Status 11 copper PLL frequency error
// - Status 13 far-end fault pattern detected
// - Status 12 copper PLL on local oscillator
// - Status 10 seed stale, latched until read and a fresh seed
// - Status 9 copper link, latched low
// - Status 8 autoneg done, non-passthrough only
// - Status 7/6 copper speed detect
// - Status 5 copper packet latched, gated
// - Status 4 FLP or PECL link pulses
// - Status 3/2 fiber speed detect
// - Status 1 fiber packet latched, gated
// - Status 0 fiber link pulse bursts
// - Passthrough when select bit is zero
`timescale 1ns/1ns
module csr_regs
  import csr_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [4:0]       reg_addr,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic             reg_rd_done,
  input  wire logic [15:0]      reg_wdata,
  output logic      [15:0]      reg_rdata,
  input  wire csr_pkg::csr_live_t live,
  output csr_pkg::csr_ctrl_t    ctrl,
  output logic                  far_fault_seen
);
  import csr_pkg::*;

  logic [15:0] ext_ctrl_q;
  logic [15:0] status_live;
  logic        seed_stale_q;
  logic        link_low_q;
  logic        cu_pkt_q;
  logic        fo_pkt_q;
  logic        rd_pend_q;
  logic [17:0] seed_cnt_q;
  logic        fsense_dis;
  logic        passthrough;
  logic        cu_spd;
  logic        fo_spd;
  logic        release_rd;
  logic        cu_again_q;
  logic        fo_again_q;
  logic        link_again_q;
  logic        stale_read_q;

  // True when the address selects the status register
  function automatic logic is_status(input logic [4:0] a);
    return a == ADDR_STATUS;
  endfunction

  assign fsense_dis  = ext_ctrl_q[CTL_FSENSE_DIS];
  assign passthrough = !live.non_passthrough;
  assign cu_spd      = live.copper_rx_fast | live.copper_rx_slow;
  assign fo_spd      = live.fiber_rx_fast | live.fiber_rx_slow;
  assign release_rd  = rd_pend_q & reg_rd_done;

  // Control register, full width read/write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ext_ctrl_q <= EXT_CTRL_RESET;
    end else if (reg_wr && reg_addr == ADDR_EXT_CTRL) begin
      ext_ctrl_q <= reg_wdata;
    end
  end

  // Control fields out to the analog and PCS logic
  assign ctrl.slow_edge_copper_tx = ext_ctrl_q[CTL_SLOW_EDGE];
  assign ctrl.freq_sense_disable  = fsense_dis;
  assign ctrl.far_fault_disable   = ext_ctrl_q[CTL_FAR_FLT_DIS];
  assign ctrl.backup_link_disable = ext_ctrl_q[CTL_BACKUP_DIS];
  assign far_fault_seen = live.far_fault_pattern
                        & !ext_ctrl_q[CTL_FAR_FLT_DIS];

  // Status read in flight, latches held until it finishes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_pend_q <= 1'b0;
    end else if (reg_rd && is_status(reg_addr)) begin
      rd_pend_q <= 1'b1;
    end else if (reg_rd_done) begin
      rd_pend_q <= 1'b0;
    end
  end

  // Events that arrive while a status read is in flight survive its release
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cu_again_q   <= 1'b0;
      fo_again_q   <= 1'b0;
      link_again_q <= 1'b0;
    end else if (release_rd) begin
      cu_again_q   <= 1'b0;
      fo_again_q   <= 1'b0;
      link_again_q <= 1'b0;
    end else if (rd_pend_q || (reg_rd && is_status(reg_addr))) begin
      cu_again_q   <= cu_again_q | live.copper_packet;
      fo_again_q   <= fo_again_q | live.fiber_packet;
      link_again_q <= link_again_q | !live.copper_link;
    end
  end

  // Remembers that the stale seed flag has been read out
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stale_read_q <= 1'b0;
    end else if (!seed_stale_q) begin
      stale_read_q <= 1'b0;
    end else if (release_rd) begin
      stale_read_q <= 1'b1;
    end
  end

  // Seed age counter, restarts on each seed update
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      seed_cnt_q <= '0;
    end else if (!live.descrambler_on || live.seed_update) begin
      seed_cnt_q <= '0;
    end else if (seed_cnt_q != 18'(SEED_STALE_CYC)) begin
      seed_cnt_q <= seed_cnt_q + 18'd1;
    end
  end

  // Stale seed flag; set wins, clear needs read and a fresh seed
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      seed_stale_q <= 1'b0;
    end else if (live.descrambler_on &&
                 seed_cnt_q == 18'(SEED_STALE_CYC)) begin
      seed_stale_q <= 1'b1;
    end else if ((release_rd || stale_read_q) && live.seed_update) begin
      seed_stale_q <= 1'b0;
    end
  end

  // Link loss latches low until read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      link_low_q <= 1'b1;
    end else if (!live.copper_link) begin
      link_low_q <= 1'b1;
    end else if (release_rd && !link_again_q) begin
      link_low_q <= 1'b0;
    end
  end

  // Packet seen flags latch high until read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cu_pkt_q <= 1'b0;
      fo_pkt_q <= 1'b0;
    end else begin
      if (live.copper_packet) begin
        cu_pkt_q <= 1'b1;
      end else if (release_rd && !cu_again_q) begin
        cu_pkt_q <= 1'b0;
      end
      if (live.fiber_packet) begin
        fo_pkt_q <= 1'b1;
      end else if (release_rd && !fo_again_q) begin
        fo_pkt_q <= 1'b0;
      end
    end
  end

  // Status word assembly
  always_comb begin
    status_live     = '0;
    status_live[15] = live.fiber_pll_on_local_osc;
    status_live[14] = live.fiber_freq_bad & !fsense_dis
                    & !live.fiber_pll_filter_rst;
    status_live[13] = far_fault_seen;
    status_live[12] = live.copper_pll_on_local_osc;
    status_live[11] = live.copper_freq_bad & !fsense_dis
                    & !live.copper_pll_filter_rst;
    status_live[10] = seed_stale_q;
    status_live[9]  = !passthrough & live.copper_link
                    & !link_low_q;
    status_live[8]  = !passthrough & live.autoneg_complete;
    status_live[7]  = live.copper_rx_fast;
    status_live[6]  = live.copper_rx_slow;
    status_live[5]  = cu_pkt_q & cu_spd;
    status_live[4]  = live.flp_burst
                    | (live.copper_pecl & live.copper_link_pulse);
    status_live[3]  = live.fiber_rx_fast;
    status_live[2]  = live.fiber_rx_slow;
    status_live[1]  = fo_pkt_q & fo_spd;
    status_live[0]  = live.fiber_link_pulse;
  end

  // Read data register, unmapped addresses read zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      if (is_status(reg_addr)) begin
        reg_rdata <= status_live;
      end else if (reg_addr == ADDR_EXT_CTRL) begin
        reg_rdata <= ext_ctrl_q;
      end else begin
        reg_rdata <= '0;
      end
    end
  end

  // Checks
  chk_ctrl_reset: assert property (@(posedge clk)
    $fell(reset) |-> ext_ctrl_q == 16'h0000)
    else $error("control not zero after reset");
  chk_write_lands: assert property (@(posedge clk)
    disable iff (reset)
    reg_wr && reg_addr == ADDR_EXT_CTRL |=> ext_ctrl_q == $past(reg_wdata))
    else $error("control write lost");
  chk_freq_gate: assert property (@(posedge clk)
    disable iff (reset)
    fsense_dis |-> !status_live[14] && !status_live[11])
    else $error("frequency error shown while disabled");
  chk_passthru_zero: assert property (@(posedge clk)
    disable iff (reset)
    passthrough |-> !status_live[9] && !status_live[8])
    else $error("link bits set in passthrough");
  chk_pkt_hold: assert property (@(posedge clk)
    disable iff (reset) live.copper_packet |=> cu_pkt_q)
    else $error("copper packet not latched");
  chk_pkt_gate: assert property (@(posedge clk)
    disable iff (reset) !fo_spd |-> !status_live[1])
    else $error("fiber packet shown without speed");
  chk_hold_no_read: assert property (@(posedge clk)
    disable iff (reset) fo_pkt_q && !release_rd |=> fo_pkt_q)
    else $error("fiber packet cleared without read");
  chk_far_fault: assert property (@(posedge clk)
    disable iff (reset) ext_ctrl_q[CTL_FAR_FLT_DIS] |-> !far_fault_seen)
    else $error("far fault seen while disabled");

  // Control outputs follow a write one cycle later; a control read returns the register
  chk_slow_edge: assert property (@(posedge clk)
    disable iff (reset) reg_wr && reg_addr == ADDR_EXT_CTRL
    |=> ctrl.slow_edge_copper_tx == $past(reg_wdata[CTL_SLOW_EDGE]))
    else $error("slow edge control wrong");
  chk_fsense_out: assert property (@(posedge clk)
    disable iff (reset) reg_wr && reg_addr == ADDR_EXT_CTRL
    |=> ctrl.freq_sense_disable == $past(reg_wdata[CTL_FSENSE_DIS]))
    else $error("frequency sense control wrong");
  chk_far_out: assert property (@(posedge clk)
    disable iff (reset) reg_wr && reg_addr == ADDR_EXT_CTRL
    |=> ctrl.far_fault_disable == $past(reg_wdata[CTL_FAR_FLT_DIS]))
    else $error("far fault control wrong");
  chk_backup_out: assert property (@(posedge clk)
    disable iff (reset) reg_wr && reg_addr == ADDR_EXT_CTRL
    |=> ctrl.backup_link_disable == $past(reg_wdata[CTL_BACKUP_DIS]))
    else $error("backup link control wrong");
  chk_rdata_ctrl: assert property (@(posedge clk)
    disable iff (reset) reg_rd && reg_addr == ADDR_EXT_CTRL
    |=> reg_rdata == $past(ext_ctrl_q))
    else $error("control read back wrong");

  // Status word gating and latches; bits 15, 12, 7:6, 3:2 and 0 reach the read data
  chk_fiber_lo: assert property (@(posedge clk)
    disable iff (reset) reg_rd && is_status(reg_addr)
    |=> reg_rdata[15] == $past(live.fiber_pll_on_local_osc))
    else $error("fiber local oscillator bit wrong");
  chk_fiber_freq: assert property (@(posedge clk)
    disable iff (reset) status_live[14] |-> live.fiber_freq_bad)
    else $error("fiber frequency error without cause");
  chk_fo_filter: assert property (@(posedge clk)
    disable iff (reset) live.fiber_pll_filter_rst |-> !status_live[14])
    else $error("fiber frequency error during filter reset");
  chk_cu_filter: assert property (@(posedge clk)
    disable iff (reset) live.copper_pll_filter_rst |-> !status_live[11])
    else $error("copper frequency error during filter reset");
  chk_cu_freq: assert property (@(posedge clk)
    disable iff (reset) status_live[11] |-> live.copper_freq_bad)
    else $error("copper frequency error without cause");
  chk_fault_bit: assert property (@(posedge clk)
    disable iff (reset) status_live[13] |-> live.far_fault_pattern)
    else $error("far fault bit without pattern");
  chk_cu_lo: assert property (@(posedge clk)
    disable iff (reset) reg_rd && is_status(reg_addr)
    |=> reg_rdata[12] == $past(live.copper_pll_on_local_osc))
    else $error("copper local oscillator bit wrong");
  chk_seed_hold: assert property (@(posedge clk)
    disable iff (reset) seed_stale_q && !live.seed_update |=> seed_stale_q)
    else $error("stale seed flag dropped without update");
  chk_link_latch: assert property (@(posedge clk)
    disable iff (reset) !live.copper_link |=> !status_live[9])
    else $error("link loss not latched");
  chk_autoneg: assert property (@(posedge clk)
    disable iff (reset) status_live[8] |-> live.autoneg_complete)
    else $error("autoneg bit without completion");
  chk_cu_speed: assert property (@(posedge clk)
    disable iff (reset) reg_rd && is_status(reg_addr)
    |=> reg_rdata[7:6] == $past({live.copper_rx_fast, live.copper_rx_slow}))
    else $error("copper speed bits wrong");
  chk_cu_gate: assert property (@(posedge clk)
    disable iff (reset) !cu_spd |-> !status_live[5])
    else $error("copper packet shown without speed");
  chk_burst: assert property (@(posedge clk)
    disable iff (reset) live.flp_burst |-> status_live[4])
    else $error("burst bit missing");
  chk_fo_speed: assert property (@(posedge clk)
    disable iff (reset) reg_rd && is_status(reg_addr)
    |=> reg_rdata[3:2] == $past({live.fiber_rx_fast, live.fiber_rx_slow}))
    else $error("fiber speed bits wrong");
  chk_fo_pkt: assert property (@(posedge clk)
    disable iff (reset) live.fiber_packet |=> fo_pkt_q)
    else $error("fiber packet not latched");
  chk_fo_pulse: assert property (@(posedge clk)
    disable iff (reset) reg_rd && is_status(reg_addr)
    |=> reg_rdata[0] == $past(live.fiber_link_pulse))
    else $error("fiber link pulse bit wrong");
  chk_again_keep: assert property (@(posedge clk)
    disable iff (reset) cu_again_q && release_rd |=> cu_pkt_q)
    else $error("packet during read lost");
endmodule

// [hdl/csr_pkg.sv]
// Package with register map, field positions and timing for converter regs
package csr_pkg;
  localparam logic [4:0]  ADDR_STATUS      = 5'h1b;
  localparam logic [4:0]  ADDR_EXT_CTRL    = 5'h1c;
  localparam logic [15:0] EXT_CTRL_RESET   = 16'h0000;
  localparam int          CTL_SLOW_EDGE    = 4;
  localparam int          CTL_FSENSE_DIS   = 3;
  localparam int          CTL_FAR_FLT_DIS  = 2;
  localparam int          CTL_BACKUP_DIS   = 1;
  localparam int          CLK_PERIOD_NS    = 10;
  localparam int          SEED_STALE_US    = 1300;
  localparam int          SEED_STALE_CYC   =
    (SEED_STALE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Live status conditions from the analog and PCS front ends
  typedef struct packed {
    logic fiber_pll_on_local_osc;
    logic fiber_freq_bad;
    logic fiber_pll_filter_rst;
    logic far_fault_pattern;
    logic copper_pll_on_local_osc;
    logic copper_freq_bad;
    logic copper_pll_filter_rst;
    logic descrambler_on;
    logic seed_update;
    logic copper_link;
    logic autoneg_complete;
    logic copper_rx_fast;
    logic copper_rx_slow;
    logic copper_packet;
    logic flp_burst;
    logic copper_pecl;
    logic copper_link_pulse;
    logic fiber_rx_fast;
    logic fiber_rx_slow;
    logic fiber_packet;
    logic fiber_link_pulse;
    logic non_passthrough;
  } csr_live_t;

  // Control outputs steered by the extended control register
  typedef struct packed {
    logic slow_edge_copper_tx;
    logic freq_sense_disable;
    logic far_fault_disable;
    logic backup_link_disable;
  } csr_ctrl_t;
endpackage

// [tb/csr_host.sv]
// Management host model issuing register reads and writes
`timescale 1ns/1ns
module csr_host (
  input  wire logic        clk,
  output logic [4:0]       reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic             reg_rd_done,
  output logic [15:0]      reg_wdata,
  input  wire logic [15:0] reg_rdata
);
  // Idle bus at time zero
  initial begin
    reg_addr = 5'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_rd_done = 1'b0;
    reg_wdata = 16'h0000;
  end

  // One write, held for a single sampling edge
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // One read, then signal that shifting out has finished
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
    reg_rd_done <= 1'b1;
    @(posedge clk);
    reg_rd_done <= 1'b0;
  endtask
endmodule

// [tb/csr_regs_test.sv]
// Self-checking bench for the converter control and status registers
`timescale 1ns/1ns
module csr_regs_test;
  import csr_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [4:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic        reg_rd_done;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [15:0] v;
  csr_live_t   live = '0;
  csr_ctrl_t   ctrl;
  logic        far_fault_seen;
  int          miscompares = 0;
  int          check_count = 0;

  csr_regs csr_regs_inst (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_done(reg_rd_done),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .live(live),
    .ctrl(ctrl), .far_fault_seen(far_fault_seen));
  csr_host csr_host_inst (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rd_done(reg_rd_done), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));

  // Clock generator, 10 ns period
  initial forever #5 clk = ~clk;

  // Compare one value and count the outcome
  task automatic compare(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // Summary and verdict
  task automatic conclude;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    conclude();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    csr_host_inst.rd(ADDR_EXT_CTRL, v);
    compare(v, EXT_CTRL_RESET);
    csr_host_inst.rd(5'h05, v);
    compare(v, 16'h0000);
    csr_host_inst.wr(ADDR_EXT_CTRL, 16'hffff);
    csr_host_inst.rd(ADDR_EXT_CTRL, v);
    compare(v, 16'hffff);
    compare({12'h000, ctrl}, 16'h000f);
    live.fiber_freq_bad <= 1'b1;
    live.copper_freq_bad <= 1'b1;
    live.far_fault_pattern <= 1'b1;
    csr_host_inst.rd(ADDR_STATUS, v);
    compare(v, 16'h0000);
    compare({15'h0000, far_fault_seen}, 16'h0000);
    csr_host_inst.wr(ADDR_EXT_CTRL, 16'h0010);
    csr_host_inst.rd(ADDR_STATUS, v);
    compare(v, 16'h6800);
    compare({12'h000, ctrl}, 16'h0008);
    compare({15'h0000, far_fault_seen}, 16'h0001);
    live.fiber_freq_bad <= 1'b0;
    live.copper_freq_bad <= 1'b0;
    live.far_fault_pattern <= 1'b0;
    live.copper_rx_fast <= 1'b1;
    @(posedge clk);
    live.copper_packet <= 1'b1;
    @(posedge clk);
    live.copper_packet <= 1'b0;
    csr_host_inst.rd(ADDR_STATUS, v);
    compare(v, 16'h00a0);
    csr_host_inst.rd(ADDR_STATUS, v);
    compare(v, 16'h0080);
    live.copper_rx_fast <= 1'b0;
    live.copper_packet <= 1'b1;
    @(posedge clk);
    live.copper_packet <= 1'b0;
    csr_host_inst.rd(ADDR_STATUS, v);
    compare(v, 16'h0000);
    live.non_passthrough <= 1'b1;
    live.autoneg_complete <= 1'b1;
    csr_host_inst.rd(ADDR_STATUS, v);
    compare(v, 16'h0100);
    live.non_passthrough <= 1'b0;
    csr_host_inst.rd(ADDR_STATUS, v);
    compare(v, 16'h0000);
    live.non_passthrough <= 1'b1;
    live.copper_link <= 1'b1;
    live.fiber_pll_on_local_osc <= 1'b1;
    live.copper_pll_on_local_osc <= 1'b1;
    live.copper_rx_slow <= 1'b1;
    live.fiber_rx_fast <= 1'b1;
    live.fiber_rx_slow <= 1'b1;
    live.fiber_link_pulse <= 1'b1;
    live.fiber_packet <= 1'b1;
    live.fiber_freq_bad <= 1'b1;
    live.fiber_pll_filter_rst <= 1'b1;
    live.copper_pecl <= 1'b1;
    live.copper_link_pulse <= 1'b1;
    @(posedge clk);
    live.fiber_packet <= 1'b0;
    csr_host_inst.rd(ADDR_STATUS, v);
    compare(v, 16'h915f);
    csr_host_inst.rd(ADDR_STATUS, v);
    compare(v, 16'h935d);
    live.copper_link <= 1'b0;
    @(posedge clk);
    live.copper_link <= 1'b1;
    csr_host_inst.rd(ADDR_STATUS, v);
    compare(v, 16'h915d);
    conclude();
  end
endmodule
